// File: src/temp_readout_pkg.sv
/*
 * Shared constants and types for the temperature readout and test coil
 * block. Assumes a 25 MHz system clock and an 8-bit register port.
 */
package temp_readout_pkg;
    // Register offsets on the byte-wide register port.
    localparam logic [7:0] DATA_HI_ADDR  = 8'hc1;
    localparam logic [7:0] DATA_LO_ADDR  = 8'hc2;
    localparam logic [7:0] SIG_SEL_ADDR  = 8'hc3;
    localparam logic [7:0] MEAS_ADDR     = 8'he0;
    localparam logic [7:0] TCOEF_ADDR    = 8'he1;
    localparam logic [7:0] COIL_ADDR     = 8'he2;
    localparam logic [7:0] NVM_LOC_ADDR  = 8'he3;
    localparam logic [7:0] NVM_DATA_ADDR = 8'he4;
    localparam logic [7:0] NVM_CTRL_ADDR = 8'he5;
    // Field positions.
    localparam int MEAS_START_BIT = 0;
    localparam int MEAS_BURST_LSB = 1;
    localparam int MEAS_BUSY_BIT  = 3;
    localparam int NVM_BUSY_BIT   = 0;
    localparam int NVM_REQ_BIT    = 1;
    // Output signal selection code for temperature.
    localparam logic [7:0] SEL_TEMP = 8'h01;
    // Test coil drive codes.
    localparam logic [1:0] COIL_POS = 2'h1;
    localparam logic [1:0] COIL_NEG = 2'h2;
    // Nonvolatile store layout.
    localparam int         NVM_DEPTH      = 64;
    localparam logic [5:0] NVM_OFFSET_LOC = 6'h1d;
    localparam logic [5:0] NVM_GAIN_LOC   = 6'h1e;
    // Compensation reference point and coefficient scaling.
    localparam logic [14:0] TEMP_REF   = 15'h4000;
    localparam int          TCOEF_SHIFT = 8;
    // Nonvolatile read time.
    localparam int CLK_PERIOD_NS = 40;
    localparam int NVM_READ_NS   = 200;
    localparam int NVM_READ_CYC  =
        (NVM_READ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [3:0] NVM_READ_CNT = 4'(NVM_READ_CYC - 1);

    typedef struct packed {
        logic [14:0] field;
        logic [14:0] temp;
    } sample_t;

    typedef enum logic {MEAS_IDLE, MEAS_WAIT} meas_state_t;
endpackage

// File: src/nvm_store.sv
/*
 * Read-only nonvolatile byte store holding the temperature correction
 * bytes. Assumes one-cycle read requests that are ignored while busy.
 */
`timescale 1ns/1ps
`default_nettype none
module nvm_store #(
    parameter logic [7:0] OFFSET_VAL = 8'h00,
    parameter logic [7:0] GAIN_VAL   = 8'h00
) (
    // Clock and reset.
    input  wire logic       sys_clk_i,
    input  wire logic       rst_i,
    // Read request.
    input  wire logic       rd_req_i,
    input  wire logic [5:0] loc_i,
    // Read answer.
    output logic      [7:0] data_o,
    output logic            busy_o
);
    logic [7:0] mem [temp_readout_pkg::NVM_DEPTH];
    logic [5:0] loc_ff;
    logic [3:0] cnt_ff;

    // Contents stand in for fused bytes; only the correction pair is set.
    always_ff @(posedge sys_clk_i) begin
        for (int i = 0; i < temp_readout_pkg::NVM_DEPTH; i++) begin
            if (6'(i) == temp_readout_pkg::NVM_OFFSET_LOC) begin
                mem[i] <= OFFSET_VAL;
            end else if (6'(i) == temp_readout_pkg::NVM_GAIN_LOC) begin
                mem[i] <= GAIN_VAL;
            end else begin
                mem[i] <= 8'h00;
            end
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            busy_o <= 1'b0;
            cnt_ff <= 4'h0;
            loc_ff <= 6'h00;
            data_o <= 8'h00;
        end else if (!busy_o) begin
            if (rd_req_i) begin
                busy_o <= 1'b1;
                cnt_ff <= temp_readout_pkg::NVM_READ_CNT;
                loc_ff <= loc_i;
            end
        end else if (cnt_ff == 4'h0) begin
            busy_o <= 1'b0;
            data_o <= mem[loc_ff];
        end else begin
            cnt_ff <= cnt_ff - 4'h1;
        end
    end
endmodule // nvm_store
`default_nettype wire

// File: src/temp_readout_and_test_coil.sv
/*
 * Temperature readout path, field compensation, burst averaging,
 * correction byte fetch and test coil drive. Assumes the converter
 * runs on sys_clk_i and answers each request with one paired sample.
 */
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Coil code 01 drives positive, 10 negative, 00 and 11 none.
// - Every field conversion brings a temperature sample with it.
// - The paired temperature compensates each field sample.
// - Writing 0x01 to the select register presents temperature data.
// - Temperature reads back as 15 bits through the data pair.
// - Temperature is readable after one conversion or a burst.
// - Bursts average field only; temperature is the last sample.
// - Offset and gain bytes sit at store locations 0x1d and 0x1e.
// - A read request bit starts a store read and clears itself.
// - A busy flag shows while a store read is in progress.
module temp_readout_and_test_coil #(
    parameter logic [7:0] OFFSET_VAL = 8'h00,
    parameter logic [7:0] GAIN_VAL   = 8'h00
) (
    // Clock and reset.
    input  wire logic                      sys_clk_i,
    input  wire logic                      rst_i,
    // Register port.
    input  wire logic [7:0]                reg_addr_i,
    input  wire logic [7:0]                reg_wdata_i,
    input  wire logic                      reg_wr_i,
    input  wire logic                      reg_rd_i,
    output logic      [7:0]                reg_rdata_o,
    // Converter.
    output logic                           conv_req_o,
    input  wire logic                      conv_done_i,
    input  wire temp_readout_pkg::sample_t conv_sample_i,
    // Test coil drive.
    output logic                           coil_pos_o,
    output logic                           coil_neg_o
);
    temp_readout_pkg::meas_state_t state_ff;
    logic [7:0]  sig_sel_ff;
    logic [1:0]  coil_ff;
    logic [7:0]  tcoef_ff;
    logic [1:0]  burst_ff;
    logic [3:0]  left_ff;
    logic [17:0] acc_ff;
    logic [14:0] field_ff;
    logic [14:0] temp_ff;
    logic [5:0]  nvm_loc_ff;
    logic        nvm_req_ff;
    logic [7:0]  nvm_data_w;
    logic        nvm_busy_w;
    logic [14:0] comp_w;
    logic [17:0] nxt_acc;
    logic [14:0] shown_w;
    logic [7:0]  nxt_rdata;
    logic        wr_meas;
    logic        start_w;

    // Temperature drift is removed linearly around a fixed reference.
    function automatic logic [14:0] compensate(
        input logic [14:0]        f,
        input logic [14:0]        t,
        input logic signed [7:0]  c
    );
        logic signed [15:0] d;
        logic signed [23:0] p;
        logic signed [17:0] s;
        begin
            d = $signed({1'b0, t}) - $signed({1'b0,
                temp_readout_pkg::TEMP_REF});
            p = d * c;
            s = $signed({3'b000, f})
                - 18'(p >>> temp_readout_pkg::TCOEF_SHIFT);
            if (s < 0) begin
                compensate = 15'h0000;
            end else if (s > $signed({3'b000, 15'h7fff})) begin
                compensate = 15'h7fff;
            end else begin
                compensate = s[14:0];
            end
        end
    endfunction

    function automatic logic wr_at(input logic [7:0] a);
        begin
            wr_at = reg_wr_i && (reg_addr_i == a);
        end
    endfunction

    assign comp_w = compensate(conv_sample_i.field, conv_sample_i.temp,
                               tcoef_ff);
    assign nxt_acc = acc_ff + {3'b000, comp_w};
    // Procedural so that the strobe read inside the function is sensed.
    always_comb begin
        wr_meas = wr_at(temp_readout_pkg::MEAS_ADDR);
    end
    assign start_w = wr_meas && reg_wdata_i[temp_readout_pkg::MEAS_START_BIT]
                     && (state_ff == temp_readout_pkg::MEAS_IDLE);

    // Control registers written by software.
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            sig_sel_ff <= 8'h00;
            coil_ff    <= 2'h0;
            tcoef_ff   <= 8'h00;
            burst_ff   <= 2'h0;
            nvm_loc_ff <= 6'h00;
        end else begin
            if (wr_at(temp_readout_pkg::SIG_SEL_ADDR)) begin
                sig_sel_ff <= reg_wdata_i;
            end
            if (wr_at(temp_readout_pkg::COIL_ADDR)) begin
                coil_ff <= reg_wdata_i[1:0];
            end
            if (wr_at(temp_readout_pkg::TCOEF_ADDR)) begin
                tcoef_ff <= reg_wdata_i;
            end
            if (wr_meas && state_ff == temp_readout_pkg::MEAS_IDLE) begin
                burst_ff <= reg_wdata_i[temp_readout_pkg::MEAS_BURST_LSB +: 2];
            end
            if (wr_at(temp_readout_pkg::NVM_LOC_ADDR)) begin
                nvm_loc_ff <= reg_wdata_i[5:0];
            end
        end
    end

    // No guard against a direct 01 to 10 step; software avoids it.
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            coil_pos_o <= 1'b0;
            coil_neg_o <= 1'b0;
        end else begin
            coil_pos_o <= (coil_ff == temp_readout_pkg::COIL_POS);
            coil_neg_o <= (coil_ff == temp_readout_pkg::COIL_NEG);
        end
    end

    // Request bit clears itself the cycle after it is set.
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            nvm_req_ff <= 1'b0;
        end else begin
            nvm_req_ff <= wr_at(temp_readout_pkg::NVM_CTRL_ADDR)
                && reg_wdata_i[temp_readout_pkg::NVM_REQ_BIT];
        end
    end

    nvm_store #(
        .OFFSET_VAL (OFFSET_VAL),
        .GAIN_VAL   (GAIN_VAL)
    ) u_nvm (
        .sys_clk_i (sys_clk_i),
        .rst_i     (rst_i),
        .rd_req_i  (nvm_req_ff),
        .loc_i     (nvm_loc_ff),
        .data_o    (nvm_data_w),
        .busy_o    (nvm_busy_w)
    );

    // Measurement sequencer: 2**burst paired conversions per start.
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            state_ff   <= temp_readout_pkg::MEAS_IDLE;
            conv_req_o <= 1'b0;
            left_ff    <= 4'h0;
            acc_ff     <= 18'h00000;
            field_ff   <= 15'h0000;
            temp_ff    <= 15'h0000;
        end else begin
            conv_req_o <= 1'b0;
            case (state_ff)
                temp_readout_pkg::MEAS_IDLE: begin
                    if (start_w) begin
                        state_ff   <= temp_readout_pkg::MEAS_WAIT;
                        conv_req_o <= 1'b1;
                        left_ff    <= 4'h1 << reg_wdata_i[
                            temp_readout_pkg::MEAS_BURST_LSB +: 2];
                        acc_ff     <= 18'h00000;
                    end
                end
                temp_readout_pkg::MEAS_WAIT: begin
                    if (conv_done_i) begin
                        temp_ff <= conv_sample_i.temp;
                        acc_ff  <= nxt_acc;
                        left_ff <= left_ff - 4'h1;
                        if (left_ff == 4'h1) begin
                            state_ff <= temp_readout_pkg::MEAS_IDLE;
                            field_ff <= 15'(nxt_acc >> burst_ff);
                        end else begin
                            conv_req_o <= 1'b1;
                        end
                    end
                end
                default: state_ff <= temp_readout_pkg::MEAS_IDLE;
            endcase
        end
    end

    // Data pair shows temperature only for the exact selection code.
    assign shown_w = (sig_sel_ff == temp_readout_pkg::SEL_TEMP)
                     ? temp_ff : field_ff;

    always_comb begin
        case (reg_addr_i)
            temp_readout_pkg::DATA_HI_ADDR:
                nxt_rdata = {1'b0, shown_w[14:8]};
            temp_readout_pkg::DATA_LO_ADDR:
                nxt_rdata = shown_w[7:0];
            temp_readout_pkg::SIG_SEL_ADDR: nxt_rdata = sig_sel_ff;
            temp_readout_pkg::MEAS_ADDR:
                nxt_rdata = {4'h0,
                    state_ff == temp_readout_pkg::MEAS_WAIT, burst_ff, 1'b0};
            temp_readout_pkg::TCOEF_ADDR: nxt_rdata = tcoef_ff;
            temp_readout_pkg::COIL_ADDR: nxt_rdata = {6'h00, coil_ff};
            temp_readout_pkg::NVM_LOC_ADDR: nxt_rdata = {2'h0, nvm_loc_ff};
            temp_readout_pkg::NVM_DATA_ADDR: nxt_rdata = nvm_data_w;
            temp_readout_pkg::NVM_CTRL_ADDR:
                nxt_rdata = {6'h00, nvm_req_ff, nvm_busy_w};
            default: nxt_rdata = 8'h00;
        endcase
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            reg_rdata_o <= 8'h00;
        end else if (reg_rd_i) begin
            reg_rdata_o <= nxt_rdata;
        end else begin
            reg_rdata_o <= 8'h00;
        end
    end

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);

    sequence last_done_s;
        state_ff == temp_readout_pkg::MEAS_WAIT && conv_done_i
            && left_ff == 4'h1;
    endsequence

    sequence nvm_offset_req_s;
        nvm_req_ff && !nvm_busy_w
            && nvm_loc_ff == temp_readout_pkg::NVM_OFFSET_LOC;
    endsequence

    coil_pos_drive_a: assert property (
        coil_ff == temp_readout_pkg::COIL_POS |=> coil_pos_o && !coil_neg_o)
        else $error("coil positive drive wrong");
    coil_off_drive_a: assert property (
        coil_ff == 2'h0 || coil_ff == 2'h3 |=> !coil_pos_o && !coil_neg_o)
        else $error("coil should carry no current");
    temp_pair_a: assert property (
        state_ff == temp_readout_pkg::MEAS_WAIT && conv_done_i
        |=> temp_ff == $past(conv_sample_i.temp))
        else $error("temperature sample not taken with field");
    field_comp_a: assert property (
        last_done_s ##0 burst_ff == 2'h0 |=> field_ff == $past(comp_w))
        else $error("single field sample not compensated");
    temp_low_read_a: assert property (
        reg_rd_i && reg_addr_i == temp_readout_pkg::DATA_LO_ADDR
        && sig_sel_ff == temp_readout_pkg::SEL_TEMP
        |=> reg_rdata_o == $past(temp_ff[7:0]))
        else $error("temperature low byte wrong");
    field_high_read_a: assert property (
        reg_rd_i && reg_addr_i == temp_readout_pkg::DATA_HI_ADDR
        && sig_sel_ff != temp_readout_pkg::SEL_TEMP
        |=> reg_rdata_o == {1'b0, $past(field_ff[14:8])})
        else $error("field high byte wrong");
    single_start_a: assert property (
        start_w |=> conv_req_o && state_ff == temp_readout_pkg::MEAS_WAIT)
        else $error("start did not request a conversion");
    nvm_req_clear_a: assert property (
        nvm_req_ff |=> !nvm_req_ff || $past(wr_at(
            temp_readout_pkg::NVM_CTRL_ADDR)))
        else $error("read request bit did not clear");
    nvm_offset_read_a: assert property (
        nvm_offset_req_s |=> nvm_busy_w [*5] ##1
        (!nvm_busy_w && nvm_data_w == OFFSET_VAL))
        else $error("offset byte read wrong");
endmodule // temp_readout_and_test_coil
`default_nettype wire

// File: sim/conv_model.sv
/*
 * Behavioural converter that answers the block's conversion requests.
 * Assumes the same clock as the block and a latency set by the bench.
 */
`timescale 1ns/1ps
`default_nettype none
module conv_model (
    // Clock and reset.
    input  wire logic                      sys_clk_i,
    input  wire logic                      rst_i,
    // Request and latency.
    input  wire logic                      conv_req_i,
    input  wire logic [3:0]                delay_i,
    input  wire temp_readout_pkg::sample_t next_i,
    // Answer.
    output logic                           conv_done_o,
    output temp_readout_pkg::sample_t      conv_sample_o,
    output logic [3:0]                     idx_o
);
    logic [3:0] wait_ff;
    logic       busy_ff;

    // Every answer carries a field and a temperature sample together.
    // Between answers the sample toggles so stale data never looks valid.
    always_ff @(posedge sys_clk_i) begin
        conv_done_o <= 1'b0;
        conv_sample_o <= ~conv_sample_o;
        if (rst_i) begin
            busy_ff <= 1'b0;
            wait_ff <= 4'h0;
            idx_o <= 4'h0;
        end else if (conv_req_i) begin
            busy_ff <= 1'b1;
            wait_ff <= delay_i;
        end else if (busy_ff && wait_ff == 4'h0) begin
            busy_ff <= 1'b0;
            conv_done_o <= 1'b1;
            conv_sample_o <= next_i;
            idx_o <= idx_o + 4'h1;
        end else if (busy_ff) begin
            wait_ff <= wait_ff - 4'h1;
        end
    end
endmodule // conv_model
`default_nettype wire

// File: sim/testbench.sv
/*
 * Self-checking bench for the temperature readout and test coil block.
 * Assumes conv_model as the converter and a 25 MHz clock.
 */
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic                      clk, rst, wr, rd, req, done, pos, neg;
    logic [7:0]                addr, wdata, rdata, ob, gb;
    logic [3:0]                dly, idx, nc;
    logic [14:0]               fq [0:15];
    logic [14:0]               tq [0:15];
    temp_readout_pkg::sample_t smp;
    int                        n_fail, compares, seed;

    temp_readout_and_test_coil #(.OFFSET_VAL(8'hf3), .GAIN_VAL(8'h2a)) dut (
        .sys_clk_i(clk), .rst_i(rst), .reg_addr_i(addr),
        .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
        .reg_rdata_o(rdata), .conv_req_o(req), .conv_done_i(done),
        .conv_sample_i(smp), .coil_pos_o(pos), .coil_neg_o(neg));
    conv_model conv (
        .sys_clk_i(clk), .rst_i(rst), .conv_req_i(req), .delay_i(dly),
        .next_i({fq[idx], tq[idx]}), .conv_done_o(done),
        .conv_sample_o(smp), .idx_o(idx));

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic wrap_up();
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [15:0] s, e);
        compares++;
        if (s !== e) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", nm, e, s);
        end
    endtask

    task automatic wrr(input logic [7:0] a, d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic rdd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask

    function automatic logic [14:0] comp(input logic [14:0] f, t,
                                         input logic [7:0] c);
        int p;
        p = int'(t) - int'(temp_readout_pkg::TEMP_REF);
        p = int'(f) - ((p * int'($signed(c))) >>> 8);
        return (p < 0) ? 15'h0 : (p > 32767) ? 15'h7fff : 15'(p);
    endfunction

    // Host conversion to hundredths of a degree at an assumed 3.3 V supply.
    function automatic int temp_cc(input logic [11:0] v,
                                   input logic [7:0] ofs, gn);
        real x, raw;
        x = v;
        raw = -3.83e-6 * x * x + 0.16094 * x - 279.80;
        return int'(100.0 * ((1.0 + real'($signed(gn)) / 2048.0) * raw
                   + real'($signed(ofs)) / 16.0 - 0.222 * 3.3));
    endfunction

    // Runs one measurement of 2**b conversions and reads it back under
    // several selections; mode 1 and 2 push compensation into its clamps.
    task automatic meas(input logic [1:0] b, input logic [7:0] c,
                        input int mode);
        logic [7:0]  d, h, l, s;
        logic [14:0] et, ef;
        int          sum, k;
        sum = 0;
        for (k = 0; k < (1 << b); k++) begin
            fq[4'(nc + k)] = (mode == 1) ? 15'h0 : (mode == 2) ? 15'h7fff
                             : 15'($random(seed));
            tq[4'(nc + k)] = (mode == 1) ? 15'h7fff : (mode == 2) ? 15'h0
                             : 15'($random(seed));
            sum += int'(comp(fq[4'(nc + k)], tq[4'(nc + k)], c));
            et = tq[4'(nc + k)];
        end
        ef = 15'(sum >> b);
        nc = 4'(nc + (1 << b));
        dly <= 4'($random(seed));
        wrr(temp_readout_pkg::TCOEF_ADDR, c);
        wrr(temp_readout_pkg::MEAS_ADDR, {5'h0, b, 1'b1});
        rdd(temp_readout_pkg::MEAS_ADDR, d);
        chk("meas busy", 16'(d[3]), 16'h1);
        k = 0;
        while (d[3] !== 1'b0 && k < 200) begin
            rdd(temp_readout_pkg::MEAS_ADDR, d);
            k++;
        end
        chk("meas done", 16'(d[3]), 16'h0);
        chk("conv count", 16'(idx), 16'(nc));
        for (k = 0; k < 5; k++) begin
            s = (k == 0) ? temp_readout_pkg::SEL_TEMP : (k == 1) ? 8'h00
                : (k == 2) ? 8'h02 : (k == 3) ? 8'h81 : 8'($random(seed));
            wrr(temp_readout_pkg::SIG_SEL_ADDR, s);
            rdd(temp_readout_pkg::DATA_HI_ADDR, h);
            rdd(temp_readout_pkg::DATA_LO_ADDR, l);
            chk("data pair", {h, l}, {1'b0, (s == 8'h01) ? et : ef});
            if (s == temp_readout_pkg::SEL_TEMP) begin
                chk("temp code", 16'(32 * int'(h[6:0]) + int'(l >> 3)),
                    16'(et[14:3]));
                chk("temp value", 16'(temp_cc(12'(32 * int'(h[6:0])
                    + int'(l >> 3)), ob, gb)), 16'(temp_cc(et[14:3], 8'hf3,
                    8'h2a)));
            end
        end
    endtask

    task automatic nvm(input logic [5:0] loc, input logic [7:0] e,
                       output logic [7:0] got);
        logic [7:0] d;
        logic       seen;
        int         k;
        seen = 1'b0;
        k = 0;
        wrr(temp_readout_pkg::NVM_LOC_ADDR, {2'h0, loc});
        wrr(temp_readout_pkg::NVM_CTRL_ADDR, 8'h02);
        do begin
            rdd(temp_readout_pkg::NVM_CTRL_ADDR, d);
            seen = seen | (d[0] === 1'b1);
            k++;
        end while ((d[0] !== 1'b0 || !seen) && k < 20);
        chk("store busy", 16'(seen), 16'h1);
        chk("store idle", 16'(d[0]), 16'h0);
        chk("store request", 16'(d[1]), 16'h0);
        rdd(temp_readout_pkg::NVM_DATA_ADDR, d);
        chk("store data", 16'(d), 16'(e));
        got = d;
        @(posedge clk);
        #1;
        chk("rdata idle", 16'(rdata), 16'h0);
    endtask

    initial begin
        logic [1:0] cs [0:8];
        logic [1:0] prev;
        logic [7:0] d;
        int         k;
        // The sequence never steps straight between the two drive codes.
        cs = '{2'h0, 2'h1, 2'h0, 2'h2, 2'h3, 2'h1, 2'h3, 2'h2, 2'h0};
        prev = 2'h0;
        seed = 32'hccf710b7;
        n_fail = 0;
        compares = 0;
        nc = 4'h0;
        dly = 4'h0;
        rst = 1'b1;
        {wr, rd, addr, wdata} = 18'h0;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        #1;
        chk("reset outputs", 16'({rdata, req, pos, neg}), 16'h0);
        wrr(8'h50, 8'hff);
        rdd(8'h50, d);
        chk("unmapped", 16'(d), 16'h0);
        for (k = 0; k < 9; k++) begin
            wrr(temp_readout_pkg::COIL_ADDR, {6'h0, cs[k]});
            #1;
            chk("coil hold", 16'({pos, neg}), 16'({prev == 2'h1,
                prev == 2'h2}));
            @(posedge clk);
            #1;
            chk("coil drive", 16'({pos, neg}), 16'({cs[k] == 2'h1,
                cs[k] == 2'h2}));
            prev = cs[k];
        end
        // Correction bytes are fetched first so readouts can use them.
        nvm(temp_readout_pkg::NVM_OFFSET_LOC, 8'hf3, ob);
        nvm(temp_readout_pkg::NVM_GAIN_LOC, 8'h2a, gb);
        meas(2'h0, 8'h00, 0);
        meas(2'h0, 8'h35, 1);
        meas(2'h1, 8'h35, 2);
        for (k = 0; k < 8; k++)
            meas(2'(k), 8'($random(seed)), 0);
        wrap_up();
    end

    // The whole sequence needs about a thousand cycles; this leaves room.
    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        wrap_up();
    end
endmodule // testbench
`default_nettype wire
